// *** uart_pkg.sv ***
// What this block does
// - Writing the transmit buffer sets its full flag; the byte is then sent.
// - Frame: start bit, eight data bits, optional parity, one or two stops.
// - Transmission start clears the transmit full flag and pulses a transmit request.
// - A second write before transfer overwrites the waiting byte.
// - Idle transmit pin level is high, or low in infrared mode.
// - Baud rate comes from base clock, clocks-per-bit adjust and divisor.
// - Before the stop bit ends, data goes to the receive buffer; full flag and request.
// - A frame finished under overrun is dropped; the buffer keeps its byte.
// - Parity mismatch sets the parity error flag and pulses a receive request.
// - A buffer read that clears a parity error still returns the receive buffer byte.
// - A zero stop bit sets the framing error flag and pulses a receive request.
// - Data bits done while buffer still full sets overrun and pulses a request.
// - While overrun stands, further frames are dropped without any request.
// - Dropped frames never set parity or framing error flags.
// - Flags seen set by a status read clear on the next buffer read.
// - Flags set after that status read survive the buffer read.
// - Reception starts on a falling edge; bits decided by majority of counts 8 to 6.
// - A start bit sampled high abandons the frame until the next falling edge.
// - Adjust codes 000 to 100 give 16, 16/17, 15, 15/16 or 17 clocks per bit.
package uart_pkg;

   localparam int ADR_W = 5;

   // Byte offsets of the word registers
   localparam logic [ADR_W-1:0] OFS_CONTROL_ONE = 5'h00;
   localparam logic [ADR_W-1:0] OFS_CONTROL_TWO = 5'h04;
   localparam logic [ADR_W-1:0] OFS_BAUD_DIV    = 5'h08;
   localparam logic [ADR_W-1:0] OFS_STATUS      = 5'h0C;
   localparam logic [ADR_W-1:0] OFS_TX_DATA     = 5'h10;
   localparam logic [ADR_W-1:0] OFS_RX_DATA     = 5'h14;

   // Control one fields
   localparam int C1_TX_ENABLE   = 0;
   localparam int C1_RX_ENABLE   = 1;
   localparam int C1_PARITY_EN   = 2;
   localparam int C1_PARITY_EVEN = 3;
   localparam int C1_STOP_TWO    = 4;
   localparam int C1_BASE_LO     = 5;
   localparam int C1_INFRARED    = 7;

   // Status fields
   localparam int ST_TX_BUSY = 0;
   localparam int ST_TX_FULL = 1;
   localparam int ST_RX_FULL = 2;
   localparam int ST_PARITY  = 3;
   localparam int ST_FRAMING = 4;
   localparam int ST_OVERRUN = 5;

   localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
   localparam logic [2:0] RST_CONTROL_TWO = 3'h0;
   localparam logic [7:0] RST_BAUD_DIV    = 8'h00;

   // Sub-bit counter values
   localparam logic [4:0] RT_SAMPLE_HI = 5'h08;
   localparam logic [4:0] RT_SAMPLE_LO = 5'h06;
   localparam logic [4:0] RT_STOP_DONE = 5'h05;
   localparam logic [4:0] RT_TOP_15    = 5'h0E;
   localparam logic [4:0] RT_TOP_16    = 5'h0F;
   localparam logic [4:0] RT_TOP_17    = 5'h10;
   localparam logic [2:0] LAST_DATA    = 3'h7;

   typedef enum logic [5:0] {
      TX_IDLE   = 6'b000001,
      TX_START  = 6'b000010,
      TX_DATA   = 6'b000100,
      TX_PARITY = 6'b001000,
      TX_STOP1  = 6'b010000,
      TX_STOP2  = 6'b100000
   } tx_state_type;

   typedef enum logic [4:0] {
      RX_IDLE   = 5'b00001,
      RX_START  = 5'b00010,
      RX_DATA   = 5'b00100,
      RX_PARITY = 5'b01000,
      RX_STOP   = 5'b10000
   } rx_state_type;

endpackage : uart_pkg

// *** baud_tick_gen.sv ***
`timescale 1ns/10ps
module baud_tick_gen (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_srst,
   // Rate setting
   input  wire logic [1:0] i_base_sel,
   input  wire logic [7:0] i_divisor,
   // Sub-bit clock pulse
   output logic            o_rt_tick
);
   import uart_pkg::*;

   typedef struct packed {
      logic [2:0] presc;
      logic [7:0] div;
      logic       tick;
   } gen_type;

   gen_type state_reg;
   gen_type state_next;

   always_comb begin
      logic [2:0] presc_top;
      presc_top = 3'h0;
      state_next = state_reg;
      state_next.tick = 1'b0;
      // Base select divides the system clock by 1, 2, 4 or 8
      presc_top = 3'((4'h1 << i_base_sel) - 4'h1);
      if (state_reg.presc >= presc_top) begin
         state_next.presc = 3'h0;
         if (state_reg.div >= i_divisor) begin
            state_next.div = 8'h00;
            state_next.tick = 1'b1;
         end else begin
            state_next.div = state_reg.div + 8'h01;
         end
      end else begin
         state_next.presc = state_reg.presc + 3'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_rt_tick = state_reg.tick;

endmodule : baud_tick_gen

// *** uart_txrx.sv ***
`timescale 1ns/10ps
module uart_txrx (
   // Clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_srst,
   // Classic Wishbone slave
   input  wire logic                      i_wb_cyc,
   input  wire logic                      i_wb_stb,
   input  wire logic                      i_wb_we,
   input  wire logic [uart_pkg::ADR_W-1:0] i_wb_adr,
   input  wire logic [3:0]                i_wb_sel,
   input  wire logic [31:0]               i_wb_dat,
   output logic      [31:0]               o_wb_dat,
   output logic                           o_wb_ack,
   // Power mode levels
   input  wire logic                      i_stop_mode,
   input  wire logic                      i_low_power_idle_mode,
   input  wire logic                      i_low_power_sleep_mode,
   // Serial line
   input  wire logic                      i_serial_in_pin,
   output logic                           o_serial_out_pin,
   // Request pulses
   output logic                           o_tx_interrupt_request,
   output logic                           o_rx_interrupt_request
);
   import uart_pkg::*;

   typedef struct packed {
      logic [7:0]   ctrl_one;
      logic [2:0]   ctrl_two;
      logic [7:0]   divisor;
      logic [7:0]   tx_buf;
      logic         tx_buffer_full_flag;
      tx_state_type tx_state;
      logic [4:0]   tx_rt;
      logic [2:0]   tx_bit;
      logic [7:0]   tx_shift;
      logic         tx_par;
      logic         tx_alt;
      logic         tx_line;
      logic         pin;
      rx_state_type rx_state;
      logic [4:0]   rx_rt;
      logic [2:0]   rx_bit;
      logic [7:0]   rx_shift;
      logic [2:0]   rx_samp;
      logic         rx_alt;
      logic         rx_drop;
      logic         rx_pbad;
      logic [7:0]   rx_buf;
      logic         rx_buffer_full_flag;
      logic         perr;
      logic         ferr;
      logic         overrun_error_flag;
      logic [3:0]   armed;
      logic         sync1;
      logic         sync2;
      logic         sync_prev;
      logic         ack;
      logic [31:0]  rdata;
      logic         tx_irq;
      logic         rx_irq;
   } state_type;

   state_type state_reg;
   state_type state_next;
   logic      rt_tick;

   // Reload value of the sub-bit counter, alternating on odd bits
   function automatic logic [4:0] rt_top(input logic [2:0] adj, input logic odd);
      case (adj)
         3'h0:    rt_top = RT_TOP_16;
         3'h1:    rt_top = odd ? RT_TOP_17 : RT_TOP_16;
         3'h2:    rt_top = RT_TOP_15;
         3'h3:    rt_top = odd ? RT_TOP_16 : RT_TOP_15;
         3'h4:    rt_top = RT_TOP_17;
         default: rt_top = RT_TOP_16;
      endcase
   endfunction : rt_top

   function automatic logic majority(input logic [2:0] s);
      majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : majority

   baud_tick_gen u_baud (
      .i_clk      (i_clk),
      .i_srst     (i_srst),
      .i_base_sel (state_reg.ctrl_one[C1_BASE_LO+1:C1_BASE_LO]),
      .i_divisor  (state_reg.divisor),
      .o_rt_tick  (rt_tick)
   );

   always_comb begin
      logic       access;
      logic       txe;
      logic       receive_enable_bit;
      logic       par_en;
      logic       par_odd;
      logic       idle_lvl;
      logic       forced;
      logic       bit_val;
      logic       fall;
      logic [7:0] status;
      access   = 1'b0;
      txe      = 1'b0;
      receive_enable_bit      = 1'b0;
      par_en   = 1'b0;
      par_odd  = 1'b0;
      idle_lvl = 1'b1;
      forced   = 1'b0;
      bit_val  = 1'b0;
      fall     = 1'b0;
      status   = 8'h00;
      state_next = state_reg;
      state_next.tx_irq = 1'b0;
      state_next.rx_irq = 1'b0;
      txe      = state_reg.ctrl_one[C1_TX_ENABLE];
      receive_enable_bit      = state_reg.ctrl_one[C1_RX_ENABLE];
      par_en   = state_reg.ctrl_one[C1_PARITY_EN];
      par_odd  = ~state_reg.ctrl_one[C1_PARITY_EVEN];
      idle_lvl = ~state_reg.ctrl_one[C1_INFRARED];
      forced   = ~txe | i_stop_mode | i_low_power_idle_mode | i_low_power_sleep_mode;

      // The edge detector compares the second stage with the third stage
      state_next.sync1     = i_serial_in_pin;
      state_next.sync2     = state_reg.sync1;
      state_next.sync_prev = state_reg.sync2;
      fall = state_reg.sync_prev & ~state_reg.sync2;

      status[ST_TX_BUSY] = (state_reg.tx_state != TX_IDLE);
      status[ST_TX_FULL] = state_reg.tx_buffer_full_flag;
      status[ST_RX_FULL] = state_reg.rx_buffer_full_flag;
      status[ST_PARITY]  = state_reg.perr;
      status[ST_FRAMING] = state_reg.ferr;
      status[ST_OVERRUN] = state_reg.overrun_error_flag;

      // Transmit engine; it runs before the bus so a same-cycle write wins
      if (!txe) begin
         state_next.tx_state = TX_IDLE;
         state_next.tx_line  = 1'b1;
      end else if (rt_tick) begin
         unique case (state_reg.tx_state)
            TX_IDLE: begin
               if (state_reg.tx_buffer_full_flag) begin
                  state_next.tx_shift = state_reg.tx_buf;
                  // Parity is latched here since the buffer may be rewritten mid-frame
                  state_next.tx_par   = ^state_reg.tx_buf;
                  state_next.tx_buffer_full_flag     = 1'b0;
                  state_next.tx_irq   = 1'b1;
                  state_next.tx_state = TX_START;
                  state_next.tx_line  = 1'b0;
                  state_next.tx_alt   = 1'b0;
                  state_next.tx_rt    = rt_top(state_reg.ctrl_two, 1'b0);
               end
            end
            default: begin
               if (state_reg.tx_rt != 5'h00) begin
                  state_next.tx_rt = state_reg.tx_rt - 5'h01;
               end else begin
                  state_next.tx_alt = ~state_reg.tx_alt;
                  state_next.tx_rt  = rt_top(state_reg.ctrl_two, ~state_reg.tx_alt);
                  unique case (state_reg.tx_state)
                     TX_START: begin
                        state_next.tx_state = TX_DATA;
                        state_next.tx_bit   = 3'h0;
                        state_next.tx_line  = state_reg.tx_shift[0];
                     end
                     TX_DATA: begin
                        if (state_reg.tx_bit == LAST_DATA) begin
                           // Parity only when enabled, else straight to stop
                           if (par_en) begin
                              state_next.tx_state = TX_PARITY;
                              state_next.tx_line  = state_reg.tx_par ^ par_odd;
                           end else begin
                              state_next.tx_state = TX_STOP1;
                              state_next.tx_line  = 1'b1;
                           end
                        end else begin
                           state_next.tx_bit   = state_reg.tx_bit + 3'h1;
                           state_next.tx_shift = {1'b0, state_reg.tx_shift[7:1]};
                           state_next.tx_line  = state_reg.tx_shift[1];
                        end
                     end
                     TX_PARITY: begin
                        state_next.tx_state = TX_STOP1;
                        state_next.tx_line  = 1'b1;
                     end
                     TX_STOP1: begin
                        if (state_reg.ctrl_one[C1_STOP_TWO]) begin
                           state_next.tx_state = TX_STOP2;
                        end else begin
                           state_next.tx_state = TX_IDLE;
                        end
                     end
                     default: begin
                        state_next.tx_state = TX_IDLE;
                     end
                  endcase
               end
            end
         endcase
      end

      // Bus access, one cycle wait then ack
      state_next.ack = 1'b0;
      access = i_wb_cyc & i_wb_stb & ~state_reg.ack;
      if (access) begin
         state_next.ack   = 1'b1;
         state_next.rdata = 32'h0000_0000;
         if (i_wb_we) begin
            if (i_wb_sel[0]) begin
               unique case (i_wb_adr)
                  OFS_CONTROL_ONE: state_next.ctrl_one = i_wb_dat[7:0];
                  OFS_CONTROL_TWO: state_next.ctrl_two = i_wb_dat[2:0];
                  OFS_BAUD_DIV:    state_next.divisor  = i_wb_dat[7:0];
                  OFS_TX_DATA: begin
                     // Overwrites a byte not yet taken by the shifter
                     state_next.tx_buf = i_wb_dat[7:0];
                     state_next.tx_buffer_full_flag   = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end else begin
            unique case (i_wb_adr)
               OFS_CONTROL_ONE: state_next.rdata[7:0] = state_reg.ctrl_one;
               OFS_CONTROL_TWO: state_next.rdata[2:0] = state_reg.ctrl_two;
               OFS_BAUD_DIV:    state_next.rdata[7:0] = state_reg.divisor;
               OFS_STATUS: begin
                  state_next.rdata[7:0] = status;
                  // Remember which flags software has now seen
                  state_next.armed = {state_reg.overrun_error_flag, state_reg.ferr,
                                      state_reg.perr, state_reg.rx_buffer_full_flag};
               end
               OFS_RX_DATA: begin
                  // Buffer is returned even when a parity error clears
                  state_next.rdata[7:0] = state_reg.rx_buf;
                  if (state_reg.armed[0]) state_next.rx_buffer_full_flag = 1'b0;
                  if (state_reg.armed[1]) state_next.perr = 1'b0;
                  if (state_reg.armed[2]) state_next.ferr = 1'b0;
                  if (state_reg.armed[3]) state_next.overrun_error_flag = 1'b0;
                  state_next.armed = 4'h0;
               end
               default: begin
               end
            endcase
         end
      end

      // Receive engine; its flag sets come last so they win over clears
      if (!receive_enable_bit) begin
         state_next.rx_state = RX_IDLE;
      end else if (state_reg.rx_state == RX_IDLE) begin
         if (fall) begin
            state_next.rx_state = RX_START;
            state_next.rx_alt   = 1'b0;
            state_next.rx_samp  = 3'h0;
            state_next.rx_rt    = rt_top(state_reg.ctrl_two, 1'b0);
         end
      end else if (rt_tick) begin
         if (state_reg.rx_rt <= RT_SAMPLE_HI && state_reg.rx_rt >= RT_SAMPLE_LO) begin
            state_next.rx_samp = {state_reg.rx_samp[1:0], state_reg.sync2};
         end
         bit_val = majority(state_next.rx_samp);
         if (state_reg.rx_state == RX_STOP && state_reg.rx_rt == RT_STOP_DONE) begin
            // Decided at count 5, before the stop bit ends, so the next start edge is caught
            state_next.rx_state = RX_IDLE;
            if (!state_reg.rx_drop) begin
               state_next.rx_buf = state_reg.rx_shift;
               state_next.rx_buffer_full_flag   = 1'b1;
               state_next.rx_irq = 1'b1;
               if (state_reg.rx_pbad) state_next.perr = 1'b1;
               if (!bit_val) state_next.ferr = 1'b1;
            end
            // A dropped frame leaves the buffer and both error flags alone
         end else if (state_reg.rx_rt != 5'h00) begin
            state_next.rx_rt = state_reg.rx_rt - 5'h01;
         end else begin
            state_next.rx_alt  = ~state_reg.rx_alt;
            state_next.rx_rt   = rt_top(state_reg.ctrl_two, ~state_reg.rx_alt);
            state_next.rx_samp = 3'h0;
            unique case (state_reg.rx_state)
               RX_START: begin
                  if (bit_val) begin
                     state_next.rx_state = RX_IDLE;
                  end else begin
                     state_next.rx_state = RX_DATA;
                     state_next.rx_bit   = 3'h0;
                  end
               end
               RX_DATA: begin
                  state_next.rx_shift = {bit_val, state_reg.rx_shift[7:1]};
                  state_next.rx_bit   = state_reg.rx_bit + 3'h1;
                  if (state_reg.rx_bit == LAST_DATA) begin
                     // Overrun still standing drops the frame even once read
                     state_next.rx_drop = state_reg.rx_buffer_full_flag | state_reg.overrun_error_flag;
                     state_next.rx_pbad = 1'b0;
                     if (state_reg.rx_buffer_full_flag && !state_reg.overrun_error_flag) begin
                        state_next.overrun_error_flag   = 1'b1;
                        state_next.rx_irq = 1'b1;
                     end
                     // With overrun already set no request goes out
                     state_next.rx_state = par_en ? RX_PARITY : RX_STOP;
                  end
               end
               RX_PARITY: begin
                  state_next.rx_pbad  = bit_val ^ (^state_reg.rx_shift ^ par_odd);
                  state_next.rx_state = RX_STOP;
               end
               default: begin
                  state_next.rx_state = RX_IDLE;
               end
            endcase
         end
      end

      // Pin sits at the idle level whenever no frame is being shifted
      if (forced || state_next.tx_state == TX_IDLE) begin
         state_next.pin = idle_lvl;
      end else begin
         state_next.pin = state_next.tx_line ^ ~idle_lvl;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_reg          <= '0;
         state_reg.ctrl_one <= RST_CONTROL_ONE;
         state_reg.ctrl_two <= RST_CONTROL_TWO;
         state_reg.divisor  <= RST_BAUD_DIV;
         state_reg.tx_state <= TX_IDLE;
         state_reg.rx_state <= RX_IDLE;
         state_reg.tx_line  <= 1'b1;
         state_reg.pin      <= 1'b1;
         state_reg.sync1    <= 1'b1;
         state_reg.sync2    <= 1'b1;
         state_reg.sync_prev <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_wb_dat               = state_reg.rdata;
   assign o_wb_ack               = state_reg.ack;
   assign o_serial_out_pin       = state_reg.pin;
   assign o_tx_interrupt_request = state_reg.tx_irq;
   assign o_rx_interrupt_request = state_reg.rx_irq;

endmodule : uart_txrx

// *** uart_txrx_asserts.sv ***
`timescale 1ns/10ps
module uart_txrx_asserts (
   input wire logic        i_clk,
   input wire logic        i_srst,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic        i_stop_mode,
   input wire logic        i_low_power_idle_mode,
   input wire logic        i_low_power_sleep_mode,
   input wire logic        i_serial_in_pin,
   input wire logic        o_serial_out_pin,
   input wire logic        o_tx_interrupt_request,
   input wire logic        o_rx_interrupt_request
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   logic [7:0] low_age_reg;
   wire logic  pwr = i_stop_mode | i_low_power_idle_mode | i_low_power_sleep_mode;
   // A receive request needs a start bit in the recent past
   always_ff @(posedge i_clk)
      if (i_srst || !i_serial_in_pin) low_age_reg <= 8'h00;
      else if (low_age_reg != 8'hFF) low_age_reg <= low_age_reg + 8'h01;
   sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
   // Three cycles so the registered pin has settled to its forced level
   sequence s_pwr_held; pwr [*3]; endsequence
   a_ack_follows_req: assert property (s_req |=> o_wb_ack) else $error("ack missing");
   a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
   a_rdat_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_reset_idle_out: assert property ($fell(i_srst) |-> o_serial_out_pin &&
      !o_tx_interrupt_request && !o_rx_interrupt_request) else $error("not idle after reset");
   a_tx_req_pulse: assert property (o_tx_interrupt_request |=> !o_tx_interrupt_request)
      else $error("tx request too long");
   a_tx_start_edge: assert property (o_tx_interrupt_request && !pwr && !$past(pwr)
      |-> o_serial_out_pin != $past(o_serial_out_pin)) else $error("no start bit");
   a_rx_req_pulse: assert property (o_rx_interrupt_request |=> !o_rx_interrupt_request)
      else $error("rx request too long");
   a_rx_needs_frame: assert property (o_rx_interrupt_request |-> low_age_reg < 8'hFA)
      else $error("rx request without frame");
   a_idle_pin_held: assert property (s_pwr_held |-> $stable(o_serial_out_pin))
      else $error("pin moved in low power");
endmodule : uart_txrx_asserts

// *** serial_peer.sv ***
`timescale 1ns/10ps
module serial_peer #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic i_clk,
   input  wire logic i_line_from_dut,
   output logic      o_line_to_dut
);
   logic [7:0] got[$];
   logic [7:0] sh;
   initial o_line_to_dut = 1'b1;
   task automatic send(input logic [7:0] d, input logic par_on, input logic bad_par,
                       input logic stop_val);
      logic [10:0] f;
      f = par_on ? {stop_val, ^d ^ bad_par, d, 1'b0} : {1'b1, stop_val, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge i_clk) o_line_to_dut <= f[i];
         repeat (BIT_CLKS - 1) @(posedge i_clk);
      end
      // Release to the idle high level so the next start is a clean edge
      @(posedge i_clk) o_line_to_dut <= 1'b1;
      repeat (BIT_CLKS) @(posedge i_clk);
   endtask : send
   task automatic glitch;
      @(posedge i_clk) o_line_to_dut <= 1'b0;
      repeat (3) @(posedge i_clk);
      o_line_to_dut <= 1'b1;
   endtask : glitch
   always begin
      @(negedge i_line_from_dut);
      repeat (BIT_CLKS / 2) @(posedge i_clk);
      for (int i = 0; i < 9; i++) begin
         sh = {i_line_from_dut, sh[7:1]};
         repeat (BIT_CLKS) @(posedge i_clk);
      end
      got.push_back(sh);
   end
endmodule : serial_peer

// *** uart_txrx_status_flags_bench.sv ***
`timescale 1ns/10ps
module uart_txrx_status_flags_bench;
   import uart_pkg::*;
   logic        clk, srst, cyc, stb, we, stop_md, slp, sin, sout, txq, rxq, ack;
   logic [4:0]  adr;
   logic [31:0] wdat, rdat, rd;
   logic [7:0]  tx_cnt = 8'h00;
   logic [7:0]  rx_cnt = 8'h00;
   int          fails, total_checks;
   uart_txrx dut (.i_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_stop_mode(stop_md), .i_low_power_idle_mode(stop_md), .i_low_power_sleep_mode(slp),
      .i_serial_in_pin(sin), .o_serial_out_pin(sout), .o_tx_interrupt_request(txq),
      .o_rx_interrupt_request(rxq));
   serial_peer peer (.i_clk(clk), .i_line_from_dut(sout), .o_line_to_dut(sin));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (txq) tx_cnt <= tx_cnt + 8'h01;
      if (rxq) rx_cnt <= rx_cnt + 8'h01;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (!ack && n < 20);
      if (!ack) begin
         fails++;
         end_sim();
      end
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task automatic st(input logic [7:0] e);
      bus(1'b0, OFS_STATUS, 8'h00);
      check(rd, {24'h000000, e});
   endtask : st
   // Length of the low run made by the start bit and a zero bit 0
   task automatic tx_low_time(input logic [7:0] d, input logic [31:0] exp);
      int n;
      n = 0;
      bus(1'b1, OFS_TX_DATA, d);
      while (sout && n < 100) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (!sout && n < 200) begin
         @(posedge clk);
         n++;
      end
      check(n, exp);
   endtask : tx_low_time
   initial begin
      {srst, cyc, stb, we, stop_md, slp, adr, wdat} = {1'b1, 42'h0};
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      check(sout, 1'b1);
      st(8'h00);
      bus(1'b0, 5'h18, 8'h00);
      check(rd, 32'h00000000);
      bus(1'b1, OFS_CONTROL_ONE, 8'h01);
      repeat (20) @(posedge clk);
      check(sout, 1'b1);
      st(8'h00);
      bus(1'b1, OFS_TX_DATA, 8'hA5);
      bus(1'b1, OFS_TX_DATA, 8'h11);
      bus(1'b1, OFS_TX_DATA, 8'h3C);
      st(8'h03);
      repeat (400) @(posedge clk);
      check(32'(peer.got.size()), 32'h00000002);
      check(peer.got[0], 8'hA5);
      check(peer.got[1], 8'h3C);
      check(tx_cnt, 8'h02);
      stop_md <= 1'b1;
      // An all-zero byte would pull the pin low if it were not held
      bus(1'b1, OFS_TX_DATA, 8'h00);
      repeat (10) @(posedge clk);
      check(sout, 1'b1);
      stop_md <= 1'b0;
      slp <= 1'b1;
      repeat (10) @(posedge clk);
      check(sout, 1'b1);
      slp <= 1'b0;
      bus(1'b1, OFS_CONTROL_ONE, 8'h80);
      repeat (4) @(posedge clk);
      check(sout, 1'b0);
      bus(1'b1, OFS_CONTROL_ONE, 8'h0E);
      peer.glitch();
      repeat (300) @(posedge clk);
      check(rx_cnt, 8'h00);
      peer.send(8'h5A, 1'b1, 1'b0, 1'b1);
      st(8'h04);
      bus(1'b0, OFS_RX_DATA, 8'h00);
      check(rd, 32'h0000005A);
      st(8'h00);
      peer.send(8'h33, 1'b1, 1'b1, 1'b1);
      st(8'h0C);
      bus(1'b0, OFS_RX_DATA, 8'h00);
      st(8'h00);
      peer.send(8'h66, 1'b1, 1'b0, 1'b0);
      st(8'h14);
      bus(1'b0, OFS_RX_DATA, 8'h00);
      st(8'h00);
      peer.send(8'h01, 1'b1, 1'b0, 1'b1);
      st(8'h04);
      peer.send(8'h02, 1'b1, 1'b0, 1'b1);
      bus(1'b0, OFS_RX_DATA, 8'h00);
      check(rd, 32'h00000001);
      st(8'h20);
      peer.send(8'h03, 1'b1, 1'b1, 1'b1);
      st(8'h20);
      check(rx_cnt, 8'h05);
      bus(1'b0, OFS_RX_DATA, 8'h00);
      st(8'h00);
      bus(1'b1, OFS_CONTROL_TWO, 8'h04);
      bus(1'b1, OFS_BAUD_DIV, 8'h01);
      bus(1'b1, OFS_CONTROL_ONE, 8'h15);
      // Two bits of seventeen ticks, one tick every second clock
      tx_low_time(8'hFE, 32'd68);
      end_sim();
   end
endmodule : uart_txrx_status_flags_bench
bind uart_txrx uart_txrx_asserts chk (.i_clk, .i_srst, .i_wb_cyc, .i_wb_stb, .o_wb_dat,
   .o_wb_ack, .i_stop_mode, .i_low_power_idle_mode, .i_low_power_sleep_mode,
   .i_serial_in_pin, .o_serial_out_pin, .o_tx_interrupt_request, .o_rx_interrupt_request);
